// file: bench/cmes_analog_model.sv
// Behavioural comparator front end with selectable inputs
`timescale 1ns/1ps

module cmes_analog_model #(
	parameter logic [3:0] PRESENT = 4'hf
) (
	input  wire logic                       clk_in,
	input  wire cmes_pkg::cmes_analog_ctl_t ctl_in,
	input  wire logic [5:0][7:0]            lv_in,
	output logic                            raw_out
);
	logic [7:0] plus_v;
	logic [7:0] minus_v;

	assign plus_v = ctl_in.plus_sel ? lv_in[1] : lv_in[0];
	// Absent inputs sit at ground
	assign minus_v = PRESENT[ctl_in.minus_sel] ?
		lv_in[2 + ctl_in.minus_sel] : 8'h00;

	// Answers a clock late, like a slow analog path
	always_ff @(posedge clk_in) begin
		raw_out <= plus_v > minus_v;
	end
endmodule : cmes_analog_model

// file: bench/comparator_event_and_mask_select_tb.sv
// Self-checking bench for the comparator event and mask select block
`timescale 1ns/1ps

`include "cmes_defs.svh"

module comparator_event_and_mask_select_tb;
	localparam logic [3:0] PRES = 4'h7;
	logic                      clk_in = 1'b0;
	logic                      rst_n_in = 1'b0;
	logic [3:0]                addr_in = 4'h0;
	logic [15:0]               wdata_in = 16'h0000;
	logic                      wr_in = 1'b0;
	logic                      rd_in = 1'b0;
	logic [15:0]               rdata;
	logic                      raw;
	cmes_pkg::cmes_analog_ctl_t actl;
	cmes_pkg::cmes_mask_srcs_t srcs = '0;
	logic [2:0]                mask;
	logic                      pinv;
	logic                      oen;
	logic                      trig;
	logic                      irq;
	logic [5:0][7:0]           lv = '0;
	int                        miscompares = 0;
	int                        n_tests = 0;
	int                        cnt = 0;

	always #10 clk_in = ~clk_in;
	always @(posedge clk_in) cnt <= cnt + int'(trig);

	cmes_analog_model #(.PRESENT(PRES)) u_ana (.clk_in(clk_in),
		.ctl_in(actl), .lv_in(lv), .raw_out(raw));
	cmes_core #(.INPUT_PRESENT(PRES)) u_dut (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
		.raw_result_in(raw), .analog_ctl_out(actl),
		.mask_srcs_in(srcs), .mask_out(mask), .pin_value_out(pinv),
		.pin_oe_n_out(oen), .trigger_out(trig), .irq_out(irq));

	task automatic results;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	task automatic chk(input string n, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rchk(input string n, input logic [3:0] a,
		input logic [15:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(n, e, rdata);
	endtask : rchk

	task automatic set_raw(input logic v);
		@(posedge clk_in);
		lv[0] <= v ? 8'hc8 : 8'h64;
		lv[2] <= 8'h96;
	endtask : set_raw

	function automatic logic eraw(logic p, logic [1:0] m);
		logic [7:0] mv;
		mv = PRES[m] ? lv[2 + m] : 8'h00;
		return (p ? lv[1] : lv[0]) > mv;
	endfunction : eraw

	function automatic logic esrc(logic [3:0] c);
		case (c)
			4'hc: return srcs.trig_18;
			4'hd: return srcs.trig_19;
			4'he: return srcs.fault_two;
			4'hf: return srcs.fault_four;
			default: return c[0] ? srcs.pwm_high[c[3:1]] : srcs.pwm_low[c[3:1]];
		endcase
	endfunction : esrc

	initial begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		results();
	end

	initial begin
		logic [15:0] w;
		logic [1:0]  md;
		logic        inv;
		logic        s;
		logic        e1;
		logic        e2;
		int          c0;
		int          p1;
		void'($urandom(47));
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int a = 0; a < 5; a++) rchk("reset", 4'(a), 16'h0000);
		wr(4'h9, 16'hffff);
		rchk("unmapped", 4'h9, 16'h0000);
		wr(`CMES_OFF_CTRL, 16'h1c2c);
		rchk("ctrl", `CMES_OFF_CTRL, 16'h0000);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in);
			// Plus side kept off ground so a grounded minus side compares
			lv <= 48'({$urandom(), $urandom()}) | 48'h0101;
			// Bit 10 is written too and must read back as zero
			w = 16'h8400 | (16'(i[2]) << 4) | 16'(i[1:0]);
			wr(`CMES_OFF_CTRL, w);
			repeat (3) @(posedge clk_in);
			rchk("result", `CMES_OFF_CTRL, (w & 16'he3ff)
				| (16'(eraw(i[2], i[1:0])) << 8));
			chk("actl", {12'h0, i[1:0], i[2], 1'b0}, {12'h0, actl});
		end
		$display("test inputs done");
		for (int c = 0; c < 16; c++) begin
			@(posedge clk_in);
			srcs <= cmes_pkg::cmes_mask_srcs_t'(16'($urandom()));
			w = {4'hf, 4'(c) ^ 4'h5, 4'(c) ^ 4'ha, 4'(c)};
			wr(`CMES_OFF_MASKSRC, w);
			@(posedge clk_in);
			#1;
			chk("mask", {13'h0, esrc(w[11:8]), esrc(w[7:4]),
				esrc(w[3:0])}, {13'h0, mask});
			rchk("masksrc", `CMES_OFF_MASKSRC, w & 16'h0fff);
		end
		$display("test masks done");
		for (int i = 0; i < 9; i++) begin
			md = i[1:0];
			inv = i[2];
			s = 1'($urandom());
			set_raw(s);
			w = 16'(i < 8) << 15 | 16'(md[0]) << 14 | 16'(inv) << 13;
			w = w | 16'(i < 8 ? md : 2'h3) << 6;
			wr(`CMES_OFF_CTRL, w);
			repeat (4) @(posedge clk_in);
			wr(`CMES_OFF_CTRL, w);
			wr(`CMES_OFF_IRQ_STAT, 16'h0001);
			wr(`CMES_OFF_IRQ_MASK, 16'(inv));
			c0 = cnt;
			set_raw(~s);
			repeat (6) @(posedge clk_in);
			p1 = cnt - c0;
			c0 = cnt;
			set_raw(s);
			repeat (6) @(posedge clk_in);
			e1 = i < 8 && (md == 3 || (md == 1 && (~s ^ inv)) ||
				(md == 2 && !(~s ^ inv)));
			e2 = i < 8 && (md == 1 || md == 2) && !e1;
			chk("trig1", 16'(e1), 16'(p1));
			chk("trig2", 16'(e2), 16'(cnt - c0));
			rchk("ctrl", `CMES_OFF_CTRL, w | 16'(e1 | e2) << 9 |
				16'(i < 8 && (s ^ inv)) << 8);
			chk("pins", {14'h0, i < 8 && (s ^ inv), !(md[0] && i < 8)},
				{14'h0, pinv, oen});
			rchk("stat", `CMES_OFF_IRQ_STAT, 16'(e1 | e2));
			chk("irq", 16'((e1 | e2) & inv), 16'(irq));
			wr(`CMES_OFF_IRQ_STAT, 16'h0001);
			rchk("stat", `CMES_OFF_IRQ_STAT, 16'h0000);
			chk("irq", 16'h0000, 16'(irq));
			$display("test event %0d done", i);
		end
		results();
	end
endmodule : comparator_event_and_mask_select_tb

// file: rtl/cmes_core.sv
// Comparator channel control, event detection and mask source select
`timescale 1ns/1ps

`include "cmes_defs.svh"

module cmes_core #(
	parameter logic [3:0] INPUT_PRESENT = 4'hf
) (
	input  wire logic                      clk_in,
	input  wire logic                      rst_n_in,
	input  wire logic [`CMES_AW-1:0]       addr_in,
	input  wire logic [15:0]               wdata_in,
	input  wire logic                      wr_in,
	input  wire logic                      rd_in,
	output logic      [15:0]               rdata_out,
	input  wire logic                      raw_result_in,
	output cmes_pkg::cmes_analog_ctl_t     analog_ctl_out,
	input  wire cmes_pkg::cmes_mask_srcs_t mask_srcs_in,
	output logic      [2:0]                mask_out,
	output logic                           pin_value_out,
	output logic                           pin_oe_n_out,
	output logic                           trigger_out,
	output logic                           irq_out
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [15:0] ctrl_q;
	logic [15:0] msk_q;
	logic        stat_q;
	logic        irqmask_q;
	logic        event_q;
	logic        adj_q;
	logic        adj_prev_q;
	logic        fire;
	logic        adj_d;
	logic        edge_rise;
	logic        edge_fall;
	logic        minus_ok;
	logic        wr_ctrl;
	cmes_pkg::cmes_det_state_t det_q;

	assign wr_ctrl = wr_in && (addr_in == `CMES_OFF_CTRL);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctrl_q <= `CMES_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= wdata_in & `CMES_CTRL_WMASK;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			msk_q <= `CMES_MSK_RESET;
		end else if (wr_in && (addr_in == `CMES_OFF_MASKSRC)) begin
			msk_q <= wdata_in & `CMES_MSK_WMASK;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			irqmask_q <= 1'b0;
		end else if (wr_in && (addr_in == `CMES_OFF_IRQ_MASK)) begin
			irqmask_q <= wdata_in[`CMES_IRQ_EVENT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Analog routing; the comparator itself sits outside

	// This channel has no amplifier bit, so the amplifier request stays
	// off and can never gate the comparator
	always_comb begin
		analog_ctl_out.amp_on    = 1'b0;
		analog_ctl_out.plus_sel  = ctrl_q[`CMES_CTRL_PLUS_SEL];
		analog_ctl_out.minus_sel =
			ctrl_q[`CMES_CTRL_MINUS_HI:`CMES_CTRL_MINUS_LO];
	end

	// A selected source that the package lacks is grounded; with the
	// minus side at zero the raw result is forced high here
	assign minus_ok = INPUT_PRESENT[analog_ctl_out.minus_sel];

	////////////////////////////////////////////////////////////////////////
	// Result and event detection

	always_comb begin
		adj_d = (minus_ok ? raw_result_in : 1'b1)
			^ ctrl_q[`CMES_CTRL_INVERT];
		if (!ctrl_q[`CMES_CTRL_ENABLE]) begin
			adj_d = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			adj_q      <= 1'b0;
			adj_prev_q <= 1'b0;
		end else begin
			adj_q      <= adj_d;
			adj_prev_q <= adj_q;
		end
	end

	assign edge_rise = adj_q && !adj_prev_q;
	assign edge_fall = !adj_q && adj_prev_q;

	// Edges are only looked for while enabled and not held
	always_comb begin
		fire = 1'b0;
		if (det_q == cmes_pkg::CMES_DET_ARMED) begin
			case (ctrl_q[`CMES_CTRL_EDGE_HI:`CMES_CTRL_EDGE_LO])
				`CMES_EDGE_ANY:  fire = edge_rise || edge_fall;
				`CMES_EDGE_FALL: fire = edge_fall;
				`CMES_EDGE_RISE: fire = edge_rise;
				default:         fire = 1'b0;
			endcase
		end
	end

	// Event bit: hardware set wins over a software write of zero
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			event_q <= 1'b0;
		end else if (fire) begin
			event_q <= 1'b1;
		end else if (wr_ctrl) begin
			event_q <= wdata_in[`CMES_CTRL_EVENT];
		end
	end

	always_comb begin
		det_q = cmes_pkg::CMES_DET_OFF;
		if (event_q) begin
			det_q = cmes_pkg::CMES_DET_HELD;
		end else if (ctrl_q[`CMES_CTRL_ENABLE]) begin
			det_q = cmes_pkg::CMES_DET_ARMED;
		end
	end

	assign trigger_out = fire;

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, write one to clear, set wins

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			stat_q <= 1'b0;
		end else if (fire) begin
			stat_q <= 1'b1;
		end else if (wr_in && (addr_in == `CMES_OFF_IRQ_STAT)
				&& wdata_in[`CMES_IRQ_EVENT]) begin
			stat_q <= 1'b0;
		end
	end

	assign irq_out = stat_q && irqmask_q;

	////////////////////////////////////////////////////////////////////////
	// Pin

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pin_value_out <= 1'b0;
			pin_oe_n_out  <= 1'b1;
		end else begin
			pin_value_out <= adj_q;
			pin_oe_n_out  <= !(ctrl_q[`CMES_CTRL_PIN_OE]
				&& ctrl_q[`CMES_CTRL_ENABLE]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_out <= 16'h0000;
		end else if (rd_in) begin
			if (addr_in == `CMES_OFF_CTRL) begin
				rdata_out <= ctrl_q;
				rdata_out[`CMES_CTRL_EVENT]  <= event_q;
				rdata_out[`CMES_CTRL_RESULT] <= adj_q;
			end else if (addr_in == `CMES_OFF_MASKSRC) begin
				rdata_out <= msk_q;
			end else if (addr_in == `CMES_OFF_IRQ_STAT) begin
				rdata_out <= {15'h0, stat_q};
			end else if (addr_in == `CMES_OFF_IRQ_MASK) begin
				rdata_out <= {15'h0, irqmask_q};
			end else begin
				rdata_out <= 16'h0000;
			end
		end else begin
			rdata_out <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Blanking mask sources, one selector per mask

	for (genvar g = 0; g < 3; g++) begin : g_mask
		cmes_mask_mux u_mux (
			.clk_in   (clk_in),
			.rst_n_in (rst_n_in),
			.sel_in   (msk_q[4*g +: 4]),
			.srcs_in  (mask_srcs_in),
			.mask_out (mask_out[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence rise_seen_s;
		!adj_prev_q && adj_q;
	endsequence

	sequence fall_seen_s;
		adj_prev_q && !adj_q;
	endsequence

	sequence pulse_done_s;
		##1 !trigger_out;
	endsequence

	disabled_quiet_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) !ctrl_q[`CMES_CTRL_ENABLE] |-> !trigger_out)
		else $error("trigger while comparator disabled");

	pin_follow_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) ctrl_q[`CMES_CTRL_PIN_OE] && ctrl_q[`CMES_CTRL_ENABLE]
		|=> !pin_oe_n_out && pin_value_out == $past(adj_q))
		else $error("pin not driven with result");

	invert_path_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) ctrl_q[`CMES_CTRL_ENABLE] && minus_ok
		&& $stable(ctrl_q) |=> adj_q == ($past(raw_result_in)
		^ $past(ctrl_q[`CMES_CTRL_INVERT])))
		else $error("result polarity wrong");

	held_block_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) event_q |-> !trigger_out)
		else $error("trigger while event held");

	event_set_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) trigger_out |=> event_q && stat_q)
		else $error("event bit not set after trigger");

	any_edge_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) !event_q && ctrl_q[`CMES_CTRL_ENABLE]
		&& ctrl_q[`CMES_CTRL_EDGE_HI:`CMES_CTRL_EDGE_LO] == `CMES_EDGE_ANY
		&& (adj_q != adj_prev_q) |-> trigger_out)
		else $error("change missed in any-edge mode");

	rise_only_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) trigger_out && ctrl_q[`CMES_CTRL_EDGE_HI:
		`CMES_CTRL_EDGE_LO] == `CMES_EDGE_RISE |-> rise_seen_s)
		else $error("rise mode fired without rise");

	fall_only_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) trigger_out && ctrl_q[`CMES_CTRL_EDGE_HI:
		`CMES_CTRL_EDGE_LO] == `CMES_EDGE_FALL |-> fall_seen_s)
		else $error("fall mode fired without fall");

	mode_off_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) ctrl_q[`CMES_CTRL_EDGE_HI:`CMES_CTRL_EDGE_LO]
		== `CMES_EDGE_OFF |-> !trigger_out)
		else $error("trigger with edges disabled");

	unimpl_zero_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) rd_in && addr_in == `CMES_OFF_CTRL
		|=> rdata_out[12:10] == 3'h0 && rdata_out[5] == 1'b0
		&& rdata_out[3:2] == 2'h0)
		else $error("unimplemented control bits nonzero");

	msk_upper_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) rd_in && addr_in == `CMES_OFF_MASKSRC
		|=> rdata_out[15:12] == 4'h0)
		else $error("mask source upper bits nonzero");

	pulse_once_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) trigger_out |-> pulse_done_s)
		else $error("trigger longer than one cycle");

	event_sticky_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) event_q && !wr_ctrl |=> event_q)
		else $error("event bit dropped without a write");

	event_quiet_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) ctrl_q[`CMES_CTRL_EDGE_HI:`CMES_CTRL_EDGE_LO]
		== `CMES_EDGE_OFF && !event_q && !wr_ctrl |=> !event_q)
		else $error("event set with edges disabled");

	result_off_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) !ctrl_q[`CMES_CTRL_ENABLE] |=> !adj_q)
		else $error("result reported while disabled");

	result_read_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) rd_in && addr_in == `CMES_OFF_CTRL
		|=> rdata_out[`CMES_CTRL_RESULT] == $past(adj_q)
		&& rdata_out[`CMES_CTRL_EVENT] == $past(event_q))
		else $error("result or event bit misreported");

	pin_off_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) !ctrl_q[`CMES_CTRL_PIN_OE] |=> pin_oe_n_out)
		else $error("pin driven while pin drive is off");

	stat_sticky_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) stat_q && !(wr_in && addr_in == `CMES_OFF_IRQ_STAT
		&& wdata_in[`CMES_IRQ_EVENT]) |=> stat_q)
		else $error("status bit dropped without a clear");

	mask_c_trig_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) msk_q[`CMES_MSK_C_LO +: 4] == `CMES_SRC_TRIG18
		|=> mask_out[2] == $past(mask_srcs_in.trig_18))
		else $error("mask C trigger source not followed");

	mask_b_trig_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) msk_q[`CMES_MSK_B_LO +: 4] == `CMES_SRC_TRIG19
		|=> mask_out[1] == $past(mask_srcs_in.trig_19))
		else $error("mask B trigger source not followed");

	mask_a_fault_a: assert property (@(posedge clk_in) disable iff
		(!rst_n_in) msk_q[`CMES_MSK_A_LO +: 4] == `CMES_SRC_FAULT4
		|=> mask_out[0] == $past(mask_srcs_in.fault_four))
		else $error("mask A fault source not followed");

endmodule : cmes_core

// file: rtl/cmes_defs.svh
// Offsets, field positions, reset values and codes of the comparator block
`ifndef CMES_DEFS_SVH
`define CMES_DEFS_SVH

`define CMES_AW            4
// Register word offsets (no offsets printed; chosen locally)
`define CMES_OFF_CTRL      4'h0
`define CMES_OFF_MASKSRC   4'h1
`define CMES_OFF_IRQ_STAT  4'h2
`define CMES_OFF_IRQ_MASK  4'h3

// Control register fields
`define CMES_CTRL_ENABLE   15
`define CMES_CTRL_PIN_OE   14
`define CMES_CTRL_INVERT   13
`define CMES_CTRL_EVENT    9
`define CMES_CTRL_RESULT   8
`define CMES_CTRL_EDGE_HI  7
`define CMES_CTRL_EDGE_LO  6
`define CMES_CTRL_PLUS_SEL 4
`define CMES_CTRL_MINUS_HI 1
`define CMES_CTRL_MINUS_LO 0
// Software-writable bits stored in the control register; event bit 9 is written separately
`define CMES_CTRL_WMASK    16'he0d3
`define CMES_CTRL_RESET    16'h0000

// Mask source register fields
`define CMES_MSK_C_LO      8
`define CMES_MSK_B_LO      4
`define CMES_MSK_A_LO      0
`define CMES_MSK_WMASK     16'h0fff
`define CMES_MSK_RESET     16'h0000

// Interrupt status/mask bits
`define CMES_IRQ_EVENT     0
`define CMES_IRQ_WMASK     16'h0001

// Edge mode codes
`define CMES_EDGE_OFF      2'h0
`define CMES_EDGE_RISE     2'h1
`define CMES_EDGE_FALL     2'h2
`define CMES_EDGE_ANY      2'h3

// Minus input select codes
`define CMES_MINUS_PIN     2'h0
`define CMES_MINUS_AMP1    2'h1
`define CMES_MINUS_AMP2    2'h2
`define CMES_MINUS_AMP3    2'h3

// Mask source codes that leave the PWM range
`define CMES_SRC_TRIG18    4'hc
`define CMES_SRC_TRIG19    4'hd
`define CMES_SRC_FAULT2    4'he
`define CMES_SRC_FAULT4    4'hf

`endif

// file: rtl/cmes_mask_mux.sv
// One blanking mask source selector
`timescale 1ns/1ps

`include "cmes_defs.svh"

module cmes_mask_mux (
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic [3:0]               sel_in,
	input  wire cmes_pkg::cmes_mask_srcs_t srcs_in,
	output logic                          mask_out
);

	logic mask_d;

	// Even codes below 0xc pick the low PWM output, odd codes the high one
	always_comb begin
		if (sel_in == `CMES_SRC_FAULT4) begin
			mask_d = srcs_in.fault_four;
		end else if (sel_in == `CMES_SRC_FAULT2) begin
			mask_d = srcs_in.fault_two;
		end else if (sel_in == `CMES_SRC_TRIG19) begin
			mask_d = srcs_in.trig_19;
		end else if (sel_in == `CMES_SRC_TRIG18) begin
			mask_d = srcs_in.trig_18;
		end else if (sel_in[0]) begin
			mask_d = srcs_in.pwm_high[sel_in[3:1]];
		end else begin
			mask_d = srcs_in.pwm_low[sel_in[3:1]];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mask_out <= 1'b0;
		end else begin
			mask_out <= mask_d;
		end
	end

endmodule : cmes_mask_mux

// file: rtl/cmes_pkg.sv
// Types shared by the comparator event and mask select block
package cmes_pkg;

	typedef struct packed {
		logic [5:0] pwm_high;
		logic [5:0] pwm_low;
		logic       trig_18;
		logic       trig_19;
		logic       fault_two;
		logic       fault_four;
	} cmes_mask_srcs_t;

	typedef struct packed {
		logic [1:0] minus_sel;
		logic       plus_sel;
		logic       amp_on;
	} cmes_analog_ctl_t;

	typedef enum logic [1:0] {
		CMES_DET_OFF   = 2'b00,
		CMES_DET_ARMED = 2'b01,
		CMES_DET_HELD  = 2'b11
	} cmes_det_state_t;

endpackage : cmes_pkg
